// [design/dac_top.sv]
// two-channel dma pointer, tally and mode word register set
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`include "dac_regs.svh"

module dac_top #(
  parameter int unsigned NUM_CH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic standby_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // transfer sequencer
  input wire logic [NUM_CH-1:0] unit_done_in,
  output dac_pkg::dac_view_s [NUM_CH-1:0] view_out
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic reg_hit(
    input logic [7:0] addr,
    input int unsigned ch,
    input logic [7:0] ofs
  );
    logic [7:0] base;
    base = 8'(ch) * `DAC_CH_STRIDE;
    reg_hit = (addr == (base + ofs));
  endfunction

  // ----------------------------------------
  // per-channel state
  // ----------------------------------------
  logic [31:0] src_q [NUM_CH];
  logic [31:0] dst_q [NUM_CH];
  logic [23:0] tally_q [NUM_CH];
  dac_pkg::dac_mode_s mode_q [NUM_CH];
  logic [31:0] src_d [NUM_CH];
  logic [31:0] dst_d [NUM_CH];
  logic [23:0] tally_d [NUM_CH];
  logic last_unit [NUM_CH];
  logic src_used [NUM_CH];
  logic dst_used [NUM_CH];
  logic size16 [NUM_CH];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic wr_src;
      logic wr_dst;
      logic wr_tally;
      logic wr_mode;
      logic end_set;

      // ----------------------------------------
      // decode and mode-derived controls
      // ----------------------------------------
      assign wr_src = wr_in & reg_hit(addr_in, g, `DAC_OFS_SRC);
      assign wr_dst = wr_in & reg_hit(addr_in, g, `DAC_OFS_DST);
      assign wr_tally = wr_in & reg_hit(addr_in, g, `DAC_OFS_TALLY);
      assign wr_mode = wr_in & reg_hit(addr_in, g, `DAC_OFS_MODE);
      assign size16[g] = (mode_q[g].unit_size == `DAC_SIZE_16);
      // ack_mode 1 moves device to memory: the read side is the strobed device
      assign src_used[g] = ~(mode_q[g].single_addr & mode_q[g].ack_mode);
      assign dst_used[g] = ~(mode_q[g].single_addr & ~mode_q[g].ack_mode);
      assign end_set = unit_done_in[g] & last_unit[g];

      // ----------------------------------------
      // next values after one unit
      // ----------------------------------------
      dac_addr_step u_src_step (
        .addr_in(src_q[g]),
        .step_in(mode_q[g].source_step),
        .size_in(mode_q[g].unit_size),
        .hold_in(~src_used[g]),
        .force16_in(size16[g]),
        .next_out(src_d[g])
      );

      dac_addr_step u_dst_step (
        .addr_in(dst_q[g]),
        .step_in(mode_q[g].dest_step),
        .size_in(mode_q[g].unit_size),
        .hold_in(~dst_used[g]),
        .force16_in(1'b0),
        .next_out(dst_d[g])
      );

      dac_tally_step u_tally_step (
        .tally_in(tally_q[g]),
        .size16_in(size16[g]),
        .next_out(tally_d[g]),
        .last_out(last_unit[g])
      );

      // ----------------------------------------
      // source pointer
      // ----------------------------------------
      // no reset: contents survive reset and standby
      always_ff @(posedge clk_in) begin
        if (wr_src) begin
          src_q[g] <= wdata_in;
        end else if (unit_done_in[g]) begin
          src_q[g] <= src_d[g];
        end
      end

      // ----------------------------------------
      // destination pointer
      // ----------------------------------------
      always_ff @(posedge clk_in) begin
        if (wr_dst) begin
          dst_q[g] <= wdata_in;
        end else if (unit_done_in[g]) begin
          dst_q[g] <= dst_d[g];
        end
      end

      // ----------------------------------------
      // transfer tally
      // ----------------------------------------
      // a software write in the same cycle as a unit wins, so a reload
      // is never half-overwritten by the sequencer
      always_ff @(posedge clk_in) begin
        if (wr_tally) begin
          tally_q[g] <= wdata_in[23:0];
        end else if (unit_done_in[g]) begin
          tally_q[g] <= tally_d[g];
        end
      end

      // ----------------------------------------
      // channel mode word
      // ----------------------------------------
      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          mode_q[g] <= `DAC_MODE_RESET;
        end else if (standby_in) begin
          mode_q[g] <= `DAC_MODE_RESET;
        end else if (wr_mode) begin
          mode_q[g] <= wdata_in[15:0];
          // end flag: zero clears, one keeps, a finishing unit sets
          mode_q[g].xfer_end <=
            end_set | (mode_q[g].xfer_end & wdata_in[`DAC_END_BIT]);
        end else if (end_set) begin
          mode_q[g].xfer_end <= 1'b1;
        end
      end

      // ----------------------------------------
      // view toward the sequencer
      // ----------------------------------------
      assign view_out[g].src_addr = src_q[g];
      assign view_out[g].dst_addr = dst_q[g];
      assign view_out[g].tally = tally_q[g];
      assign view_out[g].mode = mode_q[g];
      assign view_out[g].src_used = src_used[g];
      assign view_out[g].dst_used = dst_used[g];
    end
  endgenerate

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] rd_mux;

  // unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    for (int c = 0; c < NUM_CH; c++) begin
      if (reg_hit(addr_in, c, `DAC_OFS_SRC)) begin
        rd_mux = src_q[c];
      end
      if (reg_hit(addr_in, c, `DAC_OFS_DST)) begin
        rd_mux = dst_q[c];
      end
      if (reg_hit(addr_in, c, `DAC_OFS_TALLY)) begin
        rd_mux = {8'h00, tally_q[c]};
      end
      if (reg_hit(addr_in, c, `DAC_OFS_MODE)) begin
        rd_mux = {16'h0000, mode_q[c]};
      end
    end
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  logic [31:0] rdata_q;

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= 32'h00000000;
    end else if (rd_in) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign rdata_out = rdata_q;
endmodule // dac_top

// [include/dac_regs.svh]
// register offsets, field positions, reset values and step constants
`ifndef DAC_REGS_SVH
`define DAC_REGS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define DAC_ADDR_W 8
`define DAC_CH_STRIDE 8'h10
`define DAC_OFS_SRC 8'h00
`define DAC_OFS_DST 8'h04
`define DAC_OFS_TALLY 8'h08
`define DAC_OFS_MODE 8'h0c

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define DAC_PTR_W 32
`define DAC_TALLY_W 24
`define DAC_MODE_W 16
`define DAC_MODE_RESET 16'h0000

// ----------------------------------------
// mode word field positions
// ----------------------------------------
`define DAC_DSTEP_LSB 14
`define DAC_SSTEP_LSB 12
`define DAC_SIZE_LSB 10
`define DAC_SINGLE_BIT 3
`define DAC_END_BIT 1

// ----------------------------------------
// step codes and unit sizes
// ----------------------------------------
`define DAC_STEP_FIXED 2'h0
`define DAC_STEP_INC 2'h1
`define DAC_STEP_DEC 2'h2
`define DAC_SIZE_BYTE 2'h0
`define DAC_SIZE_WORD 2'h1
`define DAC_SIZE_LONG 2'h2
`define DAC_SIZE_16 2'h3
`define DAC_BYTES_1 32'h00000001
`define DAC_BYTES_2 32'h00000002
`define DAC_BYTES_4 32'h00000004
`define DAC_BYTES_16 32'h00000010
`define DAC_TALLY_STEP_1 24'h000001
`define DAC_TALLY_STEP_16 24'h000004

`endif

// [include/dac_pkg.sv]
// types shared by the channel register set
package dac_pkg;
  typedef logic [1:0] dac_step_t;
  typedef logic [1:0] dac_size_t;

  // channel mode word, low 16 bits
  typedef struct packed {
    dac_step_t dest_step;
    dac_step_t source_step;
    dac_size_t unit_size;
    logic auto_req;
    logic ack_mode;
    logic ack_level;
    logic req_edge;
    logic req_level;
    logic burst;
    logic single_addr;
    logic irq_en;
    logic xfer_end;
    logic enable;
  } dac_mode_s;

  // what one channel shows to the transfer sequencer
  typedef struct packed {
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [23:0] tally;
    dac_mode_s mode;
    logic src_used;
    logic dst_used;
  } dac_view_s;
endpackage

// [design/dac_addr_step.sv]
// next pointer value after one completed transfer unit
`timescale 1ns/1ns
`include "dac_regs.svh"
module dac_addr_step (
  // current state
  input wire logic [31:0] addr_in,
  input wire dac_pkg::dac_step_t step_in,
  input wire dac_pkg::dac_size_t size_in,
  // overrides
  input wire logic hold_in,
  input wire logic force16_in,
  // result
  output logic [31:0] next_out
);
  logic [31:0] delta;

  always_comb begin
    unique case (size_in)
      `DAC_SIZE_BYTE: delta = `DAC_BYTES_1;
      `DAC_SIZE_WORD: delta = `DAC_BYTES_2;
      `DAC_SIZE_LONG: delta = `DAC_BYTES_4;
      default: delta = `DAC_BYTES_16;
    endcase
  end

  always_comb begin
    if (hold_in) begin
      next_out = addr_in;
    end else if (force16_in) begin
      next_out = addr_in + `DAC_BYTES_16;
    end else if (step_in == `DAC_STEP_INC) begin
      next_out = addr_in + delta;
    end else if (step_in == `DAC_STEP_DEC) begin
      next_out = addr_in - delta;
    end else begin
      // fixed, and the prohibited code, leave the pointer alone
      next_out = addr_in;
    end
  end
endmodule // dac_addr_step

// [design/dac_tally_step.sv]
// remaining-count step: one per unit, four per 16-byte unit
`timescale 1ns/1ns
`include "dac_regs.svh"
module dac_tally_step (
  // current count
  input wire logic [23:0] tally_in,
  input wire logic size16_in,
  // result
  output logic [23:0] next_out,
  output logic last_out
);
  logic [23:0] amount;

  always_comb begin
    amount = size16_in ? `DAC_TALLY_STEP_16 : `DAC_TALLY_STEP_1;
    // zero wraps round (to all ones for single steps), so a zero count runs the full 2**24
    next_out = tally_in - amount;
    last_out = (tally_in == amount);
  end
endmodule // dac_tally_step

// [verif/dac_seq_model.sv]
// transfer sequencer model pulsing unit completions
`timescale 1ns/1ns
module dac_seq_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // command from bench
  input wire logic start_in,
  input wire logic ch_in,
  input wire logic [3:0] units_in,
  input wire logic slow_in,
  // to register set and bench
  output logic [1:0] unit_done_out,
  output logic busy_out
);
  logic [3:0] left_q;
  logic ch_q;
  logic tick_q;
  // slow mode spaces units a cycle apart, fast mode runs them back to back
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      left_q <= 4'h0;
      ch_q <= 1'b0;
      tick_q <= 1'b0;
      unit_done_out <= 2'h0;
    end else begin
      tick_q <= ~tick_q;
      unit_done_out <= 2'h0;
      if (start_in) begin
        left_q <= units_in;
        ch_q <= ch_in;
      end else if (left_q != 4'h0 && (!slow_in || tick_q)) begin
        left_q <= left_q - 4'h1;
        unit_done_out[ch_q] <= 1'b1;
      end
    end
  end
  assign busy_out = (left_q != 4'h0) || (unit_done_out != 2'h0);
endmodule // dac_seq_model

// [verif/dac_top_props.sv]
// concurrent checks on the register set ports
`timescale 1ns/1ns
module dac_top_props #(
  parameter int unsigned NUM_CH = 2
) (
  // ---
  // watched ports
  // ---
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic standby_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [NUM_CH-1:0] unit_done_in,
  input wire dac_pkg::dac_view_s [NUM_CH-1:0] view_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire dac_pkg::dac_view_s v0 = view_out[0];
  wire u0 = unit_done_in[0] && !wr_in;
  property p_idle_zero; !$past(rd_in) |-> rdata_out == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero");
  property p_tally_top;
    $past(rd_in) && $past(addr_in[3:0]) == 4'h8 |-> rdata_out[31:24] == 8'h0;
  endproperty
  a_tally_top: assert property (p_tally_top) else $error("tally top bits set");
  property p_mode_top;
    $past(rd_in) && $past(addr_in[3:0]) == 4'hc |-> rdata_out[31:16] == 16'h0;
  endproperty
  a_mode_top: assert property (p_mode_top) else $error("mode top bits set");
  property p_src16;
    u0 && v0.mode.unit_size == 2'h3 && v0.src_used |=> v0.src_addr == $past(v0.src_addr) + 32'h10;
  endproperty
  a_src16: assert property (p_src16) else $error("source not plus 16");
  property p_tally1;
    u0 && v0.mode.unit_size != 2'h3 |=> v0.tally == $past(v0.tally) - 24'h1;
  endproperty
  a_tally1: assert property (p_tally1) else $error("tally not minus one");
  property p_tally4;
    u0 && v0.mode.unit_size == 2'h3 |=> v0.tally == $past(v0.tally) - 24'h4;
  endproperty
  a_tally4: assert property (p_tally4) else $error("tally not minus four");
  property p_src_hold; rd_in && !unit_done_in[0] |=> $stable(v0.src_addr); endproperty
  a_src_hold: assert property (p_src_hold) else $error("source moved idle");
  property p_dst_fixed;
    u0 && v0.mode.dest_step == 2'h0 |=> $stable(v0.dst_addr);
  endproperty
  a_dst_fixed: assert property (p_dst_fixed) else $error("fixed dest moved");
  property p_standby; standby_in && !unit_done_in[0] |=> v0.mode == 16'h0; endproperty
  a_standby: assert property (p_standby) else $error("mode kept in standby");
  property p_src_unused;
    u0 && v0.mode.single_addr && v0.mode.ack_mode |=> $stable(v0.src_addr);
  endproperty
  a_src_unused: assert property (p_src_unused) else $error("unused source moved");
  property p_dst_unused;
    u0 && v0.mode.single_addr && !v0.mode.ack_mode |=> $stable(v0.dst_addr);
  endproperty
  a_dst_unused: assert property (p_dst_unused) else $error("unused dest moved");
endmodule // dac_top_props
bind dac_top dac_top_props #(.NUM_CH(NUM_CH)) dac_top_props_inst (.clk_in(clk_in),
  .reset_in(reset_in), .standby_in(standby_in), .addr_in(addr_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .unit_done_in(unit_done_in), .view_out(view_out));

// [verif/tb_dac_channel_address_count_control.sv]
// register level bench for the channel register set
`timescale 1ns/1ns
module tb_dac_channel_address_count_control;
  logic clk_in, reset_in, standby_in, wr_in, rd_in, start, ch, slow, busy;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [1:0] done;
  logic [3:0] units;
  dac_pkg::dac_view_s [1:0] view;
  int fail_count, total_checks;
  dac_top dac_top_inst (.clk_in(clk_in), .reset_in(reset_in), .standby_in(standby_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .unit_done_in(done), .view_out(view));
  dac_seq_model dac_seq_model_inst (.clk_in(clk_in), .reset_in(reset_in), .start_in(start),
    .ch_in(ch), .units_in(units), .slow_in(slow), .unit_done_out(done), .busy_out(busy));
  // ---
  // tasks
  // ---
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  // bounded wait so a stuck sequencer cannot hang the run
  task automatic run(input logic c, input logic [3:0] n, input logic s);
    int i;
    @(posedge clk_in);
    start <= 1'b1; ch <= c; units <= n; slow <= s;
    @(posedge clk_in);
    start <= 1'b0;
    #1;
    for (i = 0; i < 40 && busy; i++) @(posedge clk_in);
    if (busy !== 1'b0) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // ---
  // sequence
  // ---
  initial begin
    reset_in = 1'b1; standby_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; addr_in = 8'h00;
    wdata_in = 32'h0; start = 1'b0; ch = 1'b0; units = 4'h0; slow = 1'b0;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    wr(8'h00, 32'h00000100);
    wr(8'h04, 32'h00000200);
    wr(8'h08, 32'h00000002);
    rd(8'h0c, 32'h0);
    rd(8'h08, 32'h2);
    wr(8'h0c, 32'h00005800);
    run(1'b0, 4'h2, 1'b1);
    rd(8'h00, 32'h108);
    rd(8'h04, 32'h208);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h00000110);
    wr(8'h04, 32'h00000200);
    wr(8'h08, 32'h00000008);
    wr(8'h0c, 32'h0000ae00);
    run(1'b0, 4'h2, 1'b0);
    rd(8'h00, 32'h130);
    rd(8'h04, 32'h1e0);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h00001000);
    run(1'b0, 4'h1, 1'b0);
    rd(8'h08, 32'hffffff);
    rd(8'h00, 32'h131);
    rd(8'h04, 32'h1e0);
    wr(8'h0c, 32'h00005508);
    run(1'b0, 4'h1, 1'b0);
    rd(8'h00, 32'h131);
    rd(8'h04, 32'h1e2);
    wr(8'h0c, 32'h00005408);
    run(1'b0, 4'h1, 1'b0);
    rd(8'h00, 32'h133);
    rd(8'h04, 32'h1e2);
    wr(8'h10, 32'h00000300);
    wr(8'h14, 32'h00000400);
    wr(8'h18, 32'h00000001);
    wr(8'h1c, 32'h00004800);
    rd(8'h1c, 32'h4800);
    run(1'b1, 4'h1, 1'b1);
    rd(8'h14, 32'h404);
    rd(8'h18, 32'h0);
    rd(8'h10, 32'h300);
    rd(8'h20, 32'h0);
    @(posedge clk_in);
    standby_in <= 1'b1;
    @(posedge clk_in);
    standby_in <= 1'b0;
    rd(8'h1c, 32'h0);
    rd(8'h14, 32'h404);
    // load a non-zero mode so the reset below has something to clear
    wr(8'h0c, 32'h00001000);
    rd(8'h0c, 32'h1000);
    @(posedge clk_in);
    reset_in <= 1'b1;
    @(posedge clk_in);
    reset_in <= 1'b0;
    rd(8'h0c, 32'h0);
    rd(8'h00, 32'h133);
    rd(8'h08, 32'hfffffd);
    tally_and_finish();
  end
endmodule // tb_dac_channel_address_count_control
